// >>> core/dccs_sequencer.sv
// Function
// - coupler connected when point one reads 4V
// - setup done and connected engages the interlock
// - unlock needs zero current, contactors open, command
// - self-check done closes aux, starts id broadcast
// - handshake done closes both supply contactors
// - output follows vehicle charge-level requests
// - both ends exchange status while charging
// - current to zero before power contactors open
// - normal end: aux opens, then interlock releases
// - failure: stop current, open all four contactors
// - stop requests and link loss are general failures
// - overvoltage for 1s cuts current within 2s
// - decode states 1 to 3 from point one
// - report states 4 and 5 from progress
// - link loss while charging stops and protects
// - latch open 200ms starts protection
// - both points at 12V starts protection
`timescale 1ns/10ps
`default_nettype none
`include "dccs_cfg.svh"

module dccs_sequencer #(
    parameter logic [31:0] LATCH_OPEN_CYCLES = `DCCS_LATCH_OPEN_CYCLES,
    parameter logic [31:0] OV_PERSIST_CYCLES = `DCCS_OV_PERSIST_CYCLES,
    parameter logic [31:0] BCAST_CYCLES = `DCCS_BCAST_CYCLES,
    parameter logic [7:0] LVL12_MIN = `DCCS_LVL12_MIN,
    parameter logic [7:0] LVL12_MAX = `DCCS_LVL12_MAX,
    parameter logic [7:0] LVL6_MIN = `DCCS_LVL6_MIN,
    parameter logic [7:0] LVL6_MAX = `DCCS_LVL6_MAX,
    parameter logic [7:0] LVL4_MIN = `DCCS_LVL4_MIN,
    parameter logic [7:0] LVL4_MAX = `DCCS_LVL4_MAX
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] first_sense_point_voltage,
    input wire logic [7:0] second_sense_point_voltage,
    input wire logic operator_setup_done,
    input wire logic operator_unlock,
    input wire logic self_check_done,
    input wire logic comm_alive,
    input wire logic handshake_done,
    input wire logic vehicle_stop_request,
    input wire logic vehicle_terminate_request,
    input wire logic charger_fault,
    input wire logic output_current_zero,
    input wire logic output_overvoltage,
    input wire logic vehicle_contactors_open,
    input wire logic [15:0] requested_voltage,
    input wire logic [15:0] requested_current,
    output logic dc_supply_contactor_a,
    output logic dc_supply_contactor_b,
    output logic aux_supply_contactor_a,
    output logic aux_supply_contactor_b,
    output logic interlock_engaged,
    output logic [15:0] output_voltage_setpoint,
    output logic [15:0] output_current_setpoint,
    output logic stop_request_to_vehicle,
    output logic fault_latched,
    output logic overvoltage_limit,
    output logic charger_id_broadcast,
    output logic status_report,
    output dccs_pkg::dccs_chg_state_type charging_state
);

    dccs_pkg::dccs_seq_state_type state;
    dccs_pkg::dccs_seq_state_type next_state;
    dccs_pkg::dccs_chg_state_type next_charging_state;
    dccs_pkg::dccs_level_type p1_lvl;
    dccs_pkg::dccs_level_type p2_lvl;
    logic next_dc_supply_contactor;
    logic next_aux_supply_contactor;
    logic next_interlock_engaged;
    logic [15:0] next_output_voltage_setpoint;
    logic [15:0] next_output_current_setpoint;
    logic next_stop_request_to_vehicle;
    logic next_fault_latched;
    logic configured;
    logic next_configured;
    logic latch_open;
    logic latch_open_expired;
    logic ov_expired;
    logic unplugged;
    logic general_failure;
    logic unlock_ok;
    logic [31:0] bcast_count;
    logic [31:0] next_bcast_count;
    logic next_charger_id_broadcast;
    logic next_status_report;

    function automatic dccs_pkg::dccs_level_type decode_level(input logic [7:0] v);
        if (v >= LVL12_MIN && v <= LVL12_MAX) begin
            decode_level = dccs_pkg::lvl_12;
        end else if (v >= LVL6_MIN && v <= LVL6_MAX) begin
            decode_level = dccs_pkg::lvl_6;
        end else if (v >= LVL4_MIN && v <= LVL4_MAX) begin
            decode_level = dccs_pkg::lvl_4;
        end else begin
            decode_level = dccs_pkg::lvl_bad;
        end
    endfunction

    assign p1_lvl = decode_level(first_sense_point_voltage);
    assign p2_lvl = decode_level(second_sense_point_voltage);

    // latch switch open with the connector still seated
    assign latch_open = configured && p1_lvl == dccs_pkg::lvl_6
        && p2_lvl == dccs_pkg::lvl_6;
    assign unplugged = configured && p1_lvl == dccs_pkg::lvl_12
        && p2_lvl == dccs_pkg::lvl_12;

    dccs_persist #(
        .LIMIT(LATCH_OPEN_CYCLES)
    ) u_latch_timer (
        .clk(clk),
        .rst(rst),
        .run(latch_open),
        .expired(latch_open_expired)
    );

    dccs_persist #(
        .LIMIT(OV_PERSIST_CYCLES)
    ) u_ov_timer (
        .clk(clk),
        .rst(rst),
        .run(output_overvoltage),
        .expired(ov_expired)
    );

    // link loss only counts once the vehicle has been talking
    assign general_failure = vehicle_stop_request || charger_fault
        || latch_open_expired || unplugged
        || (configured && !comm_alive);

    assign unlock_ok = operator_unlock && output_current_zero
        && vehicle_contactors_open && !dc_supply_contactor_a
        && !aux_supply_contactor_a;

    always_comb begin
        next_charging_state = dccs_pkg::cs_unknown;
        if (unplugged) begin
            next_charging_state = dccs_pkg::cs_8;
        end else if (p1_lvl == dccs_pkg::lvl_12) begin
            next_charging_state = dccs_pkg::cs_1;
        end else if (latch_open) begin
            next_charging_state = dccs_pkg::cs_7;
        end else if (p1_lvl == dccs_pkg::lvl_6) begin
            next_charging_state = dccs_pkg::cs_2;
        end else if (p1_lvl == dccs_pkg::lvl_4) begin
            if (!self_check_done) begin
                next_charging_state = dccs_pkg::cs_3;
            end else if (!configured) begin
                next_charging_state = dccs_pkg::cs_4;
            end else if (comm_alive) begin
                next_charging_state = dccs_pkg::cs_5;
            end else begin
                next_charging_state = dccs_pkg::cs_6;
            end
        end
    end

    always_comb begin
        next_state = state;
        next_dc_supply_contactor = dc_supply_contactor_a;
        next_aux_supply_contactor = aux_supply_contactor_a;
        next_interlock_engaged = interlock_engaged;
        next_output_voltage_setpoint = output_voltage_setpoint;
        next_output_current_setpoint = `DCCS_ZERO_CURRENT;
        next_stop_request_to_vehicle = stop_request_to_vehicle;
        next_configured = configured;
        // a failure seen in the clearing cycle is not latched
        next_fault_latched = fault_latched;
        case (state)
            dccs_pkg::st_idle: begin
                next_stop_request_to_vehicle = 1'b0;
                next_configured = 1'b0;
                next_fault_latched = 1'b0;
                if (operator_setup_done && p1_lvl == dccs_pkg::lvl_4) begin
                    next_interlock_engaged = 1'b1;
                    next_state = dccs_pkg::st_locked;
                end
            end
            dccs_pkg::st_locked: begin
                if (unlock_ok) begin
                    next_interlock_engaged = 1'b0;
                    next_state = dccs_pkg::st_idle;
                end else if (self_check_done && p1_lvl == dccs_pkg::lvl_4) begin
                    next_aux_supply_contactor = 1'b1;
                    next_state = dccs_pkg::st_aux;
                end
            end
            dccs_pkg::st_aux: begin
                if (vehicle_stop_request || charger_fault || unplugged
                    || latch_open_expired) begin
                    next_stop_request_to_vehicle = charger_fault;
                    next_fault_latched = 1'b1;
                    next_state = dccs_pkg::st_ramp;
                end else if (handshake_done && comm_alive) begin
                    // vehicle is answering on the link from here on
                    next_configured = 1'b1;
                    next_dc_supply_contactor = 1'b1;
                    next_state = dccs_pkg::st_charge;
                end
            end
            dccs_pkg::st_charge: begin
                if (general_failure) begin
                    next_stop_request_to_vehicle = charger_fault;
                    next_fault_latched = 1'b1;
                    next_state = dccs_pkg::st_ramp;
                end else if (vehicle_terminate_request) begin
                    next_state = dccs_pkg::st_ramp;
                end else begin
                    next_output_voltage_setpoint = requested_voltage;
                    if (!ov_expired) begin
                        next_output_current_setpoint = requested_current;
                    end
                end
            end
            dccs_pkg::st_ramp: begin
                // power contactors never break live current
                if (output_current_zero) begin
                    next_dc_supply_contactor = 1'b0;
                    next_state = dccs_pkg::st_open;
                end
            end
            dccs_pkg::st_open: begin
                if (vehicle_contactors_open && (!comm_alive || fault_latched)) begin
                    next_aux_supply_contactor = 1'b0;
                    next_output_voltage_setpoint = `DCCS_ZERO_CURRENT;
                    next_state = dccs_pkg::st_release;
                end
            end
            dccs_pkg::st_release: begin
                if (unlock_ok) begin
                    next_interlock_engaged = 1'b0;
                    next_state = dccs_pkg::st_idle;
                end
            end
            default: begin
                next_state = dccs_pkg::st_ramp;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= dccs_pkg::st_idle;
            dc_supply_contactor_a <= 1'b0;
            dc_supply_contactor_b <= 1'b0;
            aux_supply_contactor_a <= 1'b0;
            aux_supply_contactor_b <= 1'b0;
            interlock_engaged <= 1'b0;
            output_voltage_setpoint <= `DCCS_ZERO_CURRENT;
            output_current_setpoint <= `DCCS_ZERO_CURRENT;
            stop_request_to_vehicle <= 1'b0;
            fault_latched <= 1'b0;
            configured <= 1'b0;
            overvoltage_limit <= 1'b0;
            charging_state <= dccs_pkg::cs_unknown;
        end else begin
            state <= next_state;
            dc_supply_contactor_a <= next_dc_supply_contactor;
            dc_supply_contactor_b <= next_dc_supply_contactor;
            aux_supply_contactor_a <= next_aux_supply_contactor;
            aux_supply_contactor_b <= next_aux_supply_contactor;
            interlock_engaged <= next_interlock_engaged;
            output_voltage_setpoint <= next_output_voltage_setpoint;
            output_current_setpoint <= next_output_current_setpoint;
            stop_request_to_vehicle <= next_stop_request_to_vehicle;
            fault_latched <= next_fault_latched;
            configured <= next_configured;
            overvoltage_limit <= ov_expired;
            charging_state <= next_charging_state;
        end
    end

    // one timer serves both periodic messages; they never run together
    always_comb begin
        next_bcast_count = bcast_count;
        next_charger_id_broadcast = 1'b0;
        next_status_report = 1'b0;
        if (state != dccs_pkg::st_aux && state != dccs_pkg::st_charge) begin
            next_bcast_count = `DCCS_RST_COUNT;
        end else if (bcast_count == `DCCS_RST_COUNT) begin
            next_bcast_count = BCAST_CYCLES - 32'h1;
            next_charger_id_broadcast = state == dccs_pkg::st_aux;
            next_status_report = state == dccs_pkg::st_charge;
        end else begin
            next_bcast_count = bcast_count - 32'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            bcast_count <= `DCCS_RST_COUNT;
            charger_id_broadcast <= 1'b0;
            status_report <= 1'b0;
        end else begin
            bcast_count <= next_bcast_count;
            charger_id_broadcast <= next_charger_id_broadcast;
            status_report <= next_status_report;
        end
    end

    default clocking cb @(posedge clk);
    endclocking

    default disable iff (rst);

    sequence s_charging_failure;
        state == dccs_pkg::st_charge && general_failure;
    endsequence

    sequence s_shutdown_begins;
        state == dccs_pkg::st_ramp && output_current_setpoint == `DCCS_ZERO_CURRENT
            && dc_supply_contactor_a;
    endsequence

    a_lock_needs_4v: assert property (
        $rose(interlock_engaged) |-> $past(p1_lvl) == dccs_pkg::lvl_4
            && $past(operator_setup_done))
        else $error("interlock engaged without a seated coupler");

    a_unlock_safe: assert property (
        $fell(interlock_engaged) |-> $past(operator_unlock)
            && $past(output_current_zero) && $past(vehicle_contactors_open)
            && !dc_supply_contactor_a && !aux_supply_contactor_a)
        else $error("interlock released while unsafe");

    a_aux_after_check: assert property (
        $rose(aux_supply_contactor_a) |-> $past(self_check_done) && interlock_engaged
            && state == dccs_pkg::st_aux ##1 charger_id_broadcast)
        else $error("aux supply closed before self-check");

    a_dc_after_handshake: assert property (
        $rose(dc_supply_contactor_a) |-> $past(handshake_done)
            && aux_supply_contactor_a && dc_supply_contactor_b)
        else $error("dc supply closed before handshake");

    a_current_follows: assert property (
        state == dccs_pkg::st_charge && !general_failure && !ov_expired
            && !vehicle_terminate_request
            |=> output_current_setpoint == $past(requested_current))
        else $error("current setpoint does not track request");

    a_open_at_zero: assert property (
        $fell(dc_supply_contactor_a) |-> $past(output_current_zero)
            && $past(output_current_setpoint) == `DCCS_ZERO_CURRENT)
        else $error("dc supply opened under current");

    a_aux_open_order: assert property (
        $fell(aux_supply_contactor_a) |-> !dc_supply_contactor_a
            && interlock_engaged && $past(vehicle_contactors_open))
        else $error("aux supply opened out of order");

    a_failure_stops: assert property (
        s_charging_failure |=> s_shutdown_begins ##1 fault_latched)
        else $error("failure did not start shutdown");

    a_ov_current_cut: assert property (
        overvoltage_limit && state == dccs_pkg::st_charge
            |-> output_current_setpoint == `DCCS_ZERO_CURRENT)
        else $error("overvoltage did not cut current");

    a_unplug_protect: assert property (
        state == dccs_pkg::st_charge && (unplugged || latch_open_expired)
            |=> state == dccs_pkg::st_ramp ##1 charging_state != dccs_pkg::cs_5)
        else $error("coupler open did not start protection");

endmodule // dccs_sequencer

`default_nettype wire

// >>> core/dccs_cfg.svh
`ifndef DCCS_CFG_SVH
`define DCCS_CFG_SVH

`define DCCS_CLK_MHZ 100

`define DCCS_LATCH_OPEN_MS 200
`define DCCS_LATCH_OPEN_CYCLES (`DCCS_LATCH_OPEN_MS * 1000 * `DCCS_CLK_MHZ)

`define DCCS_OV_PERSIST_S 1
`define DCCS_OV_PERSIST_CYCLES (`DCCS_OV_PERSIST_S * 1000000 * `DCCS_CLK_MHZ)

`define DCCS_BCAST_MS 10
`define DCCS_BCAST_CYCLES (`DCCS_BCAST_MS * 1000 * `DCCS_CLK_MHZ)

// sense levels in units of 0.1 V
`define DCCS_LVL12_MIN 8'h70
`define DCCS_LVL12_MAX 8'h80
`define DCCS_LVL6_MIN 8'h34
`define DCCS_LVL6_MAX 8'h44
`define DCCS_LVL4_MIN 8'h20
`define DCCS_LVL4_MAX 8'h30

`define DCCS_ZERO_CURRENT 16'h0000
`define DCCS_RST_COUNT 32'h0000_0000

`endif

// >>> core/dccs_pkg.sv
package dccs_pkg;

    typedef enum logic [1:0] {
        lvl_bad = 2'h0,
        lvl_4 = 2'h1,
        lvl_6 = 2'h2,
        lvl_12 = 2'h3
    } dccs_level_type;

    typedef enum logic [3:0] {
        cs_unknown = 4'h0,
        cs_1 = 4'h1,
        cs_2 = 4'h2,
        cs_3 = 4'h3,
        cs_4 = 4'h4,
        cs_5 = 4'h5,
        cs_6 = 4'h6,
        cs_7 = 4'h7,
        cs_8 = 4'h8
    } dccs_chg_state_type;

    typedef enum logic [6:0] {
        st_idle = 7'h01,
        st_locked = 7'h02,
        st_aux = 7'h04,
        st_charge = 7'h08,
        st_ramp = 7'h10,
        st_open = 7'h20,
        st_release = 7'h40
    } dccs_seq_state_type;

endpackage

// >>> core/dccs_persist.sv
`timescale 1ns/10ps
`default_nettype none
`include "dccs_cfg.svh"

// flags a condition that has held for LIMIT consecutive cycles
module dccs_persist #(
    parameter logic [31:0] LIMIT = 32'h0000_0001
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    output logic expired
);

    logic [31:0] count;
    logic [31:0] next_count;
    logic next_expired;

    always_comb begin
        next_count = count;
        next_expired = expired;
        if (!run) begin
            // any break in the condition restarts the wait
            next_count = `DCCS_RST_COUNT;
            next_expired = 1'b0;
        end else if (count >= LIMIT - 32'h1) begin
            next_expired = 1'b1;
        end else begin
            next_count = count + 32'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            count <= `DCCS_RST_COUNT;
            expired <= 1'b0;
        end else begin
            count <= next_count;
            expired <= next_expired;
        end
    end

endmodule // dccs_persist

`default_nettype wire

// >>> bench/dccs_vehicle_model.sv
`timescale 1ns/10ps
`default_nettype none

// vehicle end: broadcasts once powered, then handshakes and follows the charger contactors
module dccs_vehicle_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic aux_on,
    input wire logic dc_on,
    input wire logic plugged,
    input wire logic slow,
    input wire logic end_req,
    input wire logic stop_req,
    input wire logic cut_link,
    output logic [7:0] second_sense_point_voltage,
    output logic comm_alive,
    output logic handshake_done,
    output logic vehicle_contactors_open,
    output logic vehicle_terminate_request,
    output logic vehicle_stop_request
);
    logic [3:0] cnt;
    logic done;
    logic was_on;

    // point two is pulled to 12 V until the coupler loads it down to 6 V
    assign second_sense_point_voltage = plugged ? 8'h3c : 8'h78;
    assign vehicle_stop_request = stop_req;

    always_ff @(posedge clk) begin
        if (rst || !aux_on) begin
            cnt <= 4'h0;
            done <= 1'b0;
            was_on <= 1'b0;
            comm_alive <= 1'b0;
            handshake_done <= 1'b0;
            vehicle_contactors_open <= 1'b1;
            vehicle_terminate_request <= 1'b0;
        end else begin
            cnt <= (cnt == 4'hf) ? cnt : cnt + 4'h1;
            was_on <= dc_on;
            // once the power path has closed and reopened the link is wound down
            done <= done | (was_on & !dc_on);
            comm_alive <= plugged && !cut_link && !done && cnt >= 4'h2;
            handshake_done <= comm_alive && !slow && !done;
            vehicle_contactors_open <= !dc_on;
            vehicle_terminate_request <= end_req && comm_alive;
        end
    end
endmodule // dccs_vehicle_model

`default_nettype wire

// >>> bench/dccs_sequencer_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "dccs_cfg.svh"

module dccs_sequencer_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] first_sense_point_voltage, second_sense_point_voltage;
    logic operator_setup_done, operator_unlock, self_check_done, comm_alive, handshake_done;
    logic vehicle_stop_request, vehicle_terminate_request, charger_fault, output_current_zero;
    logic output_overvoltage, vehicle_contactors_open, plugged, slow, end_req, stop_req, cut_link;
    logic [15:0] requested_voltage, requested_current, output_voltage_setpoint;
    logic [15:0] output_current_setpoint;
    logic dc_supply_contactor_a, dc_supply_contactor_b, aux_supply_contactor_a;
    logic aux_supply_contactor_b, interlock_engaged, stop_request_to_vehicle, fault_latched;
    logic overvoltage_limit, charger_id_broadcast, status_report;
    dccs_pkg::dccs_chg_state_type charging_state;
    logic [31:0] seed = 32'h491ef800;
    int errors = 0;
    int tests_run = 0;
    int n;
    logic [31:0] r;

    always #5 clk = ~clk;

    dccs_sequencer #(.LATCH_OPEN_CYCLES(32'h14), .OV_PERSIST_CYCLES(32'h1e),
        .BCAST_CYCLES(32'h8)) i_dccs_sequencer (.clk, .rst, .first_sense_point_voltage,
        .second_sense_point_voltage, .operator_setup_done, .operator_unlock,
        .self_check_done, .comm_alive, .handshake_done, .vehicle_stop_request,
        .vehicle_terminate_request, .charger_fault, .output_current_zero, .output_overvoltage,
        .vehicle_contactors_open, .requested_voltage, .requested_current,
        .dc_supply_contactor_a, .dc_supply_contactor_b, .aux_supply_contactor_a,
        .aux_supply_contactor_b, .interlock_engaged, .output_voltage_setpoint,
        .output_current_setpoint, .stop_request_to_vehicle, .fault_latched,
        .overvoltage_limit, .charger_id_broadcast, .status_report, .charging_state);

    dccs_vehicle_model i_dccs_vehicle_model (.clk, .rst,
        .aux_on(aux_supply_contactor_a & aux_supply_contactor_b),
        .dc_on(dc_supply_contactor_a & dc_supply_contactor_b), .plugged, .slow, .end_req,
        .stop_req, .cut_link, .second_sense_point_voltage, .comm_alive, .handshake_done,
        .vehicle_contactors_open, .vehicle_terminate_request, .vehicle_stop_request);

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // behavioural decode: a value drawn inside band k must read as state k+1
    function automatic logic [7:0] band(int k, logic [31:0] v);
        int lo[3] = '{`DCCS_LVL12_MIN, `DCCS_LVL6_MIN, `DCCS_LVL4_MIN};
        int hi[3] = '{`DCCS_LVL12_MAX, `DCCS_LVL6_MAX, `DCCS_LVL4_MAX};
        return 8'(lo[k] + v % (hi[k] - lo[k] + 1));
    endfunction

    function automatic logic pick(int k);
        case (k)
            0: return interlock_engaged;
            1: return aux_supply_contactor_a & aux_supply_contactor_b;
            2: return dc_supply_contactor_a & dc_supply_contactor_b;
            3: return output_current_setpoint == 16'h0000;
            default: return fault_latched;
        endcase
    endfunction

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(string name, logic [15:0] exp, logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", name, exp, got);
            errors++;
        end
    endtask

    task automatic wait_for(string name, int k, logic v, int lim);
        #1;
        for (int i = 0; i < lim && pick(k) !== v; i++) begin
            @(posedge clk);
            #1;
        end
        check(name, 16'(v), 16'(pick(k)));
        if (pick(k) !== v)
            final_report();
    endtask

    task automatic count_pulses(int which);
        n = 0;
        repeat (32) begin
            @(posedge clk);
            #1;
            if ((which == 0 ? charger_id_broadcast : status_report) === 1'b1)
                n++;
        end
    endtask

    task automatic open_session();
        @(posedge clk);
        first_sense_point_voltage <= band(2, rnd());
        plugged <= 1'b1;
        operator_setup_done <= 1'b1;
        self_check_done <= 1'b1;
        wait_for("interlock on", 0, 1'b1, 10);
        wait_for("aux on", 1, 1'b1, 10);
    endtask

    task automatic unlock_and_close();
        @(posedge clk);
        operator_unlock <= 1'b1;
        // setup is withdrawn so idle cannot lock the coupler again
        operator_setup_done <= 1'b0;
        wait_for("interlock off", 0, 1'b0, 10);
        @(posedge clk);
        {operator_setup_done, self_check_done, operator_unlock, stop_req, charger_fault} <= '0;
        {cut_link, end_req, output_current_zero, plugged} <= '0;
        first_sense_point_voltage <= 8'h78;
        repeat (3) @(posedge clk);
        #1;
        check("lock stays off", 16'h0, 16'(interlock_engaged));
    endtask

    initial begin
        {operator_setup_done, operator_unlock, self_check_done, charger_fault} = '0;
        {output_current_zero, output_overvoltage, plugged, slow, end_req, stop_req} = '0;
        cut_link = 1'b0;
        first_sense_point_voltage = 8'h78;
        requested_voltage = 16'h0000;
        requested_current = 16'h0000;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        #1;
        check("reset contactors", 16'h0, {pick(0), pick(1), pick(2), fault_latched});
        check("reset state", 16'h0, charging_state);
        for (int i = 0; i < 12; i++) begin
            r = rnd();
            @(posedge clk);
            first_sense_point_voltage <= band(r % 3, r >> 8);
            repeat (2) @(posedge clk);
            #1;
            check("decoded state", 16'(r % 3 + 1), charging_state);
        end
        $display("test decode done");
        slow <= 1'b1;
        open_session();
        count_pulses(0);
        check("id pulses", 16'h4, 16'(n));
        check("state four", 16'h4, charging_state);
        slow <= 1'b0;
        wait_for("dc on", 2, 1'b1, 30);
        count_pulses(1);
        check("status pulses", 16'h4, 16'(n));
        check("state five", 16'h5, charging_state);
        repeat (4) begin
            r = rnd();
            requested_voltage <= r[31:16];
            requested_current <= r[15:0] | 16'h0001;
            repeat (3) @(posedge clk);
            #1;
            check("voltage setpoint", requested_voltage, output_voltage_setpoint);
            check("current setpoint", requested_current, output_current_setpoint);
        end
        output_overvoltage <= 1'b1;
        repeat (25) @(posedge clk);
        #1;
        check("ov early", 16'h0, 16'(pick(3)));
        wait_for("ov cut", 3, 1'b1, 10);
        check("ov flag", 16'h1, 16'(overvoltage_limit));
        output_overvoltage <= 1'b0;
        operator_unlock <= 1'b1;
        repeat (5) @(posedge clk);
        #1;
        check("unlock refused", 16'h1, 16'(interlock_engaged));
        operator_unlock <= 1'b0;
        end_req <= 1'b1;
        wait_for("ramp down", 3, 1'b1, 10);
        repeat (5) @(posedge clk);
        #1;
        check("dc held", 16'h1, 16'(pick(2)));
        output_current_zero <= 1'b1;
        wait_for("dc off", 2, 1'b0, 10);
        wait_for("aux off", 1, 1'b0, 20);
        check("interlock kept", 16'h1, 16'(interlock_engaged));
        check("no fault", 16'h0, 16'(fault_latched));
        unlock_and_close();
        $display("test normal session done");
        for (int f = 0; f < 5; f++) begin
            open_session();
            wait_for("dc on", 2, 1'b1, 30);
            @(posedge clk);
            case (f)
                0: stop_req <= 1'b1;
                1: charger_fault <= 1'b1;
                2: cut_link <= 1'b1;
                3: begin
                    first_sense_point_voltage <= 8'h78;
                    plugged <= 1'b0;
                end
                default: first_sense_point_voltage <= 8'h3c;
            endcase
            if (f == 4) begin
                repeat (15) @(posedge clk);
                #1;
                check("latch early", 16'h0, 16'(pick(3)));
            end
            wait_for("fail stop", 3, 1'b1, 30);
            wait_for("fault flag", 4, 1'b1, 5);
            check("stop to vehicle", 16'(f == 1), 16'(stop_request_to_vehicle));
            n = (f == 4) ? 7 : f * 2 + 2;
            if (f >= 2)
                check("chg state", 16'(n), 16'(charging_state));
            check("dc held", 16'h1, 16'(pick(2)));
            output_current_zero <= 1'b1;
            wait_for("dc off", 2, 1'b0, 10);
            wait_for("aux off", 1, 1'b0, 20);
            unlock_and_close();
            $display("test failure %0d done", f);
        end
        final_report();
    end

    initial begin
        repeat (100000) @(posedge clk);
        errors++;
        final_report();
    end
endmodule // dccs_sequencer_tb

`default_nettype wire
